//--- verilog/fdm_pkg.sv
// package of constants and types for the fault trouble code manager
package fdm_pkg;
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int SPN_W = 19;
    localparam int FMI_W = 5;
    localparam int OC_W = 7;
    localparam int DLY_W = 16;
    localparam int CLK_MHZ = 250;
    // one second periodic slot and five second startup hold-off
    localparam int PERIOD_MS = 1000;
    localparam int STARTUP_MS = 5000;
    localparam int MS_CYC = CLK_MHZ * 1000;
    localparam int PERIOD_CYC = PERIOD_MS * MS_CYC;
    localparam int STARTUP_CYC = STARTUP_MS * MS_CYC;
    // register map, byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_IRQ = 12'h008;
    localparam logic [11:0] ADDR_MASK = 12'h00C;
    localparam logic [11:0] ADDR_MSG0 = 12'h010;
    localparam logic [11:0] ADDR_MSG1 = 12'h014;
    localparam logic [11:0] ADDR_CH_BASE = 12'h100;
    localparam logic [11:0] ADDR_CH_SPAN = 12'h010;
    // per-channel words: +0 spn, +4 fmi/lamp/latch, +8 delay, +C state
    localparam logic [3:0] CH_SPN = 4'h0;
    localparam logic [3:0] CH_CFG = 4'h4;
    localparam logic [3:0] CH_DLY = 4'h8;
    localparam logic [3:0] CH_STA = 4'hC;
    localparam int CFG_FMI_LSB = 0;
    localparam int CFG_LAMP_LSB = 8;
    localparam int CFG_LATCH_BIT = 12;
    // reset values, then accepted mode code limits
    localparam logic [FMI_W-1:0] FMI_RST = 5'h1F;
    localparam logic [1:0] LAMP_RST = 2'h1;
    localparam logic [DLY_W-1:0] DLY_RST = 16'h0064;
    localparam logic [FMI_W-1:0] FMI_MAX_STD = 5'h15;
    localparam logic [FMI_W-1:0] FMI_COND = 5'h1F;
    // interrupt bits
    localparam int IRQ_ACT = 0;
    localparam int IRQ_NONE = 1;
    localparam int IRQ_MSG = 2;
    localparam int IRQ_W = 3;
    typedef enum logic [1:0] {
        FDM_IDLE, FDM_QUAL, FDM_ACTIVE, FDM_PREV
    } fdm_chst_t;
endpackage

//--- verilog/fdm_channel.sv
// one debounce and occurrence-count channel
`timescale 1ns/100ps
module fdm_channel
    import fdm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic faultIn,
    input wire logic [DLY_W-1:0] qualDelay,
    input wire logic latchUntilClear,
    input wire logic clearActive,
    input wire logic spnChanged,
    output logic reported,
    output logic becameActive,
    output logic [OC_W-1:0] occCount,
    output fdm_chst_t chState
);
    typedef struct packed {
        fdm_chst_t st;
        logic [DLY_W-1:0] cnt;
        logic [OC_W-1:0] oc;
        logic rise;
    } fdm_ch_t;
    fdm_ch_t s_r;
    fdm_ch_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // debounce state machine
    always_comb begin
        s_nxt = s_r;
        s_nxt.rise = 1'b0;
        case (s_r.st)
            FDM_IDLE, FDM_PREV: begin
                if (faultIn) begin
                    s_nxt.st = FDM_QUAL; // RULE1
                    s_nxt.cnt = qualDelay;
                end
            end
            FDM_QUAL: begin
                if (!faultIn) begin
                    s_nxt.st = FDM_IDLE; // RULE17
                    s_nxt.cnt = qualDelay;
                end else if (s_r.cnt == '0) begin
                    s_nxt.st = FDM_ACTIVE; // RULE2
                    s_nxt.rise = 1'b1;
                    if (s_r.oc != '1) begin
                        s_nxt.oc = s_r.oc + 1'b1; // RULE18
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            FDM_ACTIVE: begin
                if (latchUntilClear) begin
                    if (clearActive && !faultIn) begin
                        s_nxt.st = FDM_PREV; // RULE6
                    end
                end else if (!faultIn) begin
                    s_nxt.st = FDM_PREV; // RULE5
                end
            end
            default: s_nxt.st = FDM_IDLE;
        endcase
        if (spnChanged) begin
            s_nxt.oc = '0; // RULE9
        end
    end

    // state register; reset clears the count, no retained log
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '{st: FDM_IDLE, cnt: '0, oc: '0, rise: 1'b0};
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    assign reported = (s_r.st == FDM_ACTIVE);
    assign becameActive = s_r.rise;
    assign occCount = s_r.oc; // RULE4
    assign chState = s_r.st;
endmodule

//--- verilog/fdm_manager.sv
// fault trouble code manager top with apb registers and message builder
//
// Behaviour
// RULE1 - new fault starts qualify delay countdown
// RULE2 - fault held through delay: active, count up
// RULE3 - new active code sends message at once
// RULE4 - occurrence count kept in retained storage; here reset clears it
// RULE5 - default: fault gone clears code to previous
// RULE6 - latch option holds code until clear request
// RULE7 - lamp byte from channel lamp selection
// RULE8 - zero parameter number sends no message
// RULE9 - parameter number change zeroes occurrence count
// RULE10 - mode code accepts 0 to 21, 31
// RULE11 - mode code has reset default
// RULE12 - no automatic high/low mode pairing
// RULE13 - no active codes: empty message each second
// RULE14 - last code inactive sends empty message
// RULE15 - no message before startup delay
// RULE16 - code is parameter, mode, method, count
// RULE17 - fault gone early abandons countdown, reloads
// RULE18 - occurrence count saturates
`timescale 1ns/100ps
module fdm_manager
    import fdm_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter int STARTUP_CYCLES = STARTUP_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [NUM_CH-1:0] faultRaw,
    input wire logic clearActiveReq,
    input wire logic msgReady,
    output logic msgValid,
    output logic [7:0] msgLamp,
    output logic [31:0] msgCode,
    output logic msgEmpty,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        logic [NUM_CH-1:0][SPN_W-1:0] spn;
        logic [NUM_CH-1:0][FMI_W-1:0] fmi;
        logic [NUM_CH-1:0][1:0] lamp;
        logic [NUM_CH-1:0] latch;
        logic [NUM_CH-1:0][DLY_W-1:0] dly;
        logic [NUM_CH-1:0] f1;
        logic [NUM_CH-1:0] f2;
        logic clr1;
        logic clr2;
        logic clrD;
        logic [IRQ_W-1:0] irqSt;
        logic [IRQ_W-1:0] irqMask;
        logic [31:0] tick;
        logic started;
        logic [NUM_CH-1:0] pend;
        logic sendEmpty;
        logic anyPrev;
        logic [CH_W-1:0] scan;
        logic mValid;
        logic [7:0] mLamp;
        logic [31:0] mCode;
        logic mEmpty;
        logic [31:0] rdata;
    } fdm_top_t;
    fdm_top_t s_r;
    fdm_top_t s_nxt;

    logic [NUM_CH-1:0] rep;
    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] spnChg;
    logic [NUM_CH-1:0][OC_W-1:0] oc;
    fdm_chst_t chSt [NUM_CH];
    logic clearPulse;

    ////////////////////////////////////////////////////////////////////////
    // channels, one per fault input
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gCh
            fdm_channel uCh (
                .clk(clk),
                .reset(reset),
                .clkEn(clkEn),
                .faultIn(s_r.f2[g] && (s_r.spn[g] != '0)), // RULE8
                .qualDelay(s_r.dly[g]),
                .latchUntilClear(s_r.latch[g]),
                .clearActive(clearPulse),
                .spnChanged(spnChg[g]),
                .reported(rep[g]),
                .becameActive(rise[g]),
                .occCount(oc[g]),
                .chState(chSt[g])
            );
        end
    endgenerate

    assign clearPulse = s_r.clr2 && !s_r.clrD; // RULE6

    ////////////////////////////////////////////////////////////////////////
    // apb access decode and next state
    logic wr;
    logic rd;
    logic [CH_W-1:0] chIdx;
    logic [3:0] chOff;
    logic inCh;
    logic okAddr;
    logic [CH_W-1:0] k;
    logic [FMI_W-1:0] wFmi;
    logic emptyEvt;
    always_comb begin
        s_nxt = s_r;
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        chIdx = paddr[7:4];
        chOff = paddr[3:0];
        inCh = (paddr[11:8] == ADDR_CH_BASE[11:8]);
        okAddr = 1'b1;
        spnChg = '0;
        k = '0;
        wFmi = pwdata[CFG_FMI_LSB +: FMI_W];
        emptyEvt = 1'b0;
        // pin-level inputs pass two flops
        s_nxt.f1 = faultRaw;
        s_nxt.f2 = s_r.f1;
        s_nxt.clr1 = clearActiveReq;
        s_nxt.clr2 = s_r.clr1;
        s_nxt.clrD = s_r.clr2;
        if (paddr[1:0] != 2'h0) begin
            okAddr = 1'b0;
        end else if (inCh) begin
            okAddr = 1'b1;
        end else if (paddr == ADDR_CTRL || paddr == ADDR_STAT ||
                     paddr == ADDR_IRQ || paddr == ADDR_MASK ||
                     paddr == ADDR_MSG0 || paddr == ADDR_MSG1) begin
            okAddr = 1'b1;
        end else begin
            okAddr = 1'b0;
        end
        // register reads captured in setup phase
        if (rd) begin
            s_nxt.rdata = '0;
            if (inCh && chOff == CH_SPN) begin
                s_nxt.rdata[SPN_W-1:0] = s_r.spn[chIdx];
            end else if (inCh && chOff == CH_CFG) begin
                s_nxt.rdata[CFG_FMI_LSB +: FMI_W] = s_r.fmi[chIdx];
                s_nxt.rdata[CFG_LAMP_LSB +: 2] = s_r.lamp[chIdx];
                s_nxt.rdata[CFG_LATCH_BIT] = s_r.latch[chIdx];
            end else if (inCh && chOff == CH_DLY) begin
                s_nxt.rdata[DLY_W-1:0] = s_r.dly[chIdx];
            end else if (inCh && chOff == CH_STA) begin
                s_nxt.rdata[OC_W-1:0] = oc[chIdx];
                s_nxt.rdata[9:8] = chSt[chIdx];
            end else if (paddr == ADDR_STAT) begin
                s_nxt.rdata[NUM_CH-1:0] = rep;
                s_nxt.rdata[16] = s_r.started;
            end else if (paddr == ADDR_IRQ) begin
                s_nxt.rdata[IRQ_W-1:0] = s_r.irqSt;
            end else if (paddr == ADDR_MASK) begin
                s_nxt.rdata[IRQ_W-1:0] = s_r.irqMask;
            end else if (paddr == ADDR_MSG0) begin
                s_nxt.rdata[7:0] = s_r.mLamp;
                s_nxt.rdata[8] = s_r.mEmpty;
            end else if (paddr == ADDR_MSG1) begin
                s_nxt.rdata = s_r.mCode;
            end
        end
        // register writes
        if (wr && okAddr) begin
            if (inCh && chOff == CH_SPN) begin
                s_nxt.spn[chIdx] = pwdata[SPN_W-1:0];
                if (pwdata[SPN_W-1:0] != s_r.spn[chIdx]) begin
                    spnChg[chIdx] = 1'b1; // RULE9
                end
            end else if (inCh && chOff == CH_CFG) begin
                // RULE10 RULE12
                if (wFmi <= FMI_MAX_STD || wFmi == FMI_COND) begin
                    s_nxt.fmi[chIdx] = wFmi;
                end
                s_nxt.lamp[chIdx] = pwdata[CFG_LAMP_LSB +: 2];
                s_nxt.latch[chIdx] = pwdata[CFG_LATCH_BIT];
            end else if (inCh && chOff == CH_DLY) begin
                s_nxt.dly[chIdx] = pwdata[DLY_W-1:0];
            end else if (paddr == ADDR_MASK) begin
                s_nxt.irqMask = pwdata[IRQ_W-1:0];
            end else if (paddr == ADDR_IRQ) begin
                s_nxt.irqSt = s_r.irqSt & ~pwdata[IRQ_W-1:0];
            end
        end
        // startup hold-off and periodic slot
        if (!s_r.started) begin
            if (s_r.tick >= 32'(STARTUP_CYCLES - 1)) begin
                s_nxt.started = 1'b1; // RULE15
                s_nxt.tick = '0;
            end else begin
                s_nxt.tick = s_r.tick + 32'h1;
            end
        end else if (s_r.tick >= 32'(PERIOD_CYCLES - 1)) begin
            s_nxt.tick = '0;
            if (rep == '0) begin
                s_nxt.sendEmpty = 1'b1; // RULE13
                emptyEvt = 1'b1;
            end
        end else begin
            s_nxt.tick = s_r.tick + 32'h1;
        end
        // new codes and last-code-gone requests
        s_nxt.pend = s_nxt.pend | rise; // RULE3
        s_nxt.anyPrev = (rep != '0);
        if (s_r.anyPrev && rep == '0) begin
            s_nxt.sendEmpty = 1'b1; // RULE14
            emptyEvt = 1'b1;
        end
        // message output handshake
        if (s_r.mValid && msgReady) begin
            s_nxt.mValid = 1'b0;
        end
        if (!s_nxt.mValid && s_r.started) begin
            if (s_r.pend != '0) begin
                for (int i = NUM_CH - 1; i >= 0; i--) begin
                    if (s_r.pend[i]) begin
                        k = CH_W'(i);
                    end
                end
                s_nxt.pend[k] = rise[k]; // a fresh rise wins
                if (rep[k]) begin
                    s_nxt.mValid = 1'b1;
                    s_nxt.mEmpty = 1'b0;
                    s_nxt.mLamp = '0;
                    s_nxt.mLamp[{s_r.lamp[k], 1'b0} +: 2] = 2'h1; // RULE7
                    // RULE16
                    s_nxt.mCode = {1'b0, oc[k], s_r.spn[k][18:16],
                                   s_r.fmi[k], s_r.spn[k][15:0]};
                end
            end else if (s_r.sendEmpty) begin
                s_nxt.sendEmpty = emptyEvt; // a request made now survives
                // stale request dropped once a code is active
                if (rep == '0) begin
                    s_nxt.mValid = 1'b1;
                    s_nxt.mEmpty = 1'b1;
                    s_nxt.mLamp = '0;
                    s_nxt.mCode = '0;
                end
            end
        end
        // sticky events; set wins over clear
        if (s_nxt.mValid && !s_r.mValid) begin
            s_nxt.irqSt[IRQ_MSG] = 1'b1;
        end
        if (rise != '0) begin
            s_nxt.irqSt[IRQ_ACT] = 1'b1;
        end
        if (s_r.anyPrev && rep == '0) begin
            s_nxt.irqSt[IRQ_NONE] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                s_r.fmi[i] <= FMI_RST; // RULE11
                s_r.lamp[i] <= LAMP_RST;
                s_r.dly[i] <= DLY_RST;
            end
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign msgValid = s_r.mValid;
    assign msgLamp = s_r.mLamp;
    assign msgCode = s_r.mCode;
    assign msgEmpty = s_r.mEmpty;
    assign irq = |(s_r.irqSt & s_r.irqMask);
    assign prdata = s_r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !okAddr;
endmodule

//--- tb/fdm_manager_asserts.sv
// port assertions for the fault trouble code manager
`timescale 1ns/100ps
module fdm_manager_asserts
    import fdm_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter int STARTUP_CYCLES = STARTUP_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [NUM_CH-1:0] faultRaw,
    input wire logic clearActiveReq,
    input wire logic msgReady,
    input wire logic msgValid,
    input wire logic [7:0] msgLamp,
    input wire logic [31:0] msgCode,
    input wire logic msgEmpty,
    input wire logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int upCnt_r;
    // cycles since reset release, saturating at the hold-off
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            upCnt_r <= 0;
        end else if (upCnt_r < STARTUP_CYCLES) begin
            upCnt_r <= upCnt_r + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_offer; msgValid && !msgReady; endsequence
    sequence s_full; msgValid && !msgEmpty; endsequence
    property p_startHold; msgValid |-> upCnt_r >= STARTUP_CYCLES - 1;
    endproperty
    property p_held; s_offer |=> msgValid && $stable(msgCode)
        && $stable(msgLamp) && $stable(msgEmpty); endproperty
    property p_codeForm; s_full |-> !msgCode[31] && msgCode[30:24] != 7'h00;
    endproperty
    property p_lamp; s_full |-> $onehot(msgLamp & 8'h55)
        && (msgLamp & 8'hAA) == 8'h00; endproperty
    property p_emptyForm; msgValid && msgEmpty |-> msgLamp == 8'h00
        && msgCode == 32'h0; endproperty
    property p_spnSet; s_full |-> msgCode[23:21] != 3'h0
        || msgCode[15:0] != 16'h0; endproperty
    property p_mode; s_full |-> msgCode[20:16] <= FMI_MAX_STD
        || msgCode[20:16] == FMI_COND; endproperty
    property p_slvErr; pslverr |-> psel && penable; endproperty
    a_startHold: assert property (p_startHold)
        else $error("message before startup hold-off");
    a_held: assert property (p_held)
        else $error("message changed before taken");
    a_codeForm: assert property (p_codeForm)
        else $error("bad code layout");
    a_lamp: assert property (p_lamp)
        else $error("bad lamp byte");
    a_emptyForm: assert property (p_emptyForm)
        else $error("empty message not blank");
    a_spnSet: assert property (p_spnSet)
        else $error("code sent with zero parameter");
    a_mode: assert property (p_mode)
        else $error("mode code out of set");
    a_slvErr: assert property (p_slvErr)
        else $error("error outside access phase");
endmodule

//--- tb/fdm_net_node.sv
// network node model: takes messages, issues clear requests
`timescale 1ns/100ps
module fdm_net_node (
    input wire logic clk,
    input wire logic reset,
    input wire logic msgValid,
    input wire logic [7:0] msgLamp,
    input wire logic [31:0] msgCode,
    input wire logic msgEmpty,
    input wire logic slow,
    input wire logic clearCmd,
    output logic msgReady,
    output logic clearActiveReq,
    output int fullCnt,
    output int emptyCnt,
    output logic [7:0] lastLamp,
    output logic [31:0] lastCode
);
    int waitCnt;
    // accept each message after a one cycle stall, or after a five cycle stall when slow
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            msgReady <= 1'h0;
            clearActiveReq <= 1'h0;
            waitCnt <= 0;
            fullCnt <= 0;
            emptyCnt <= 0;
            lastLamp <= 8'h00;
            lastCode <= 32'h0;
        end else begin
            clearActiveReq <= clearCmd;
            if (msgValid && msgReady) begin
                msgReady <= 1'h0;
                waitCnt <= 0;
                if (msgEmpty) begin
                    emptyCnt <= emptyCnt + 1;
                end else begin
                    fullCnt <= fullCnt + 1;
                    lastLamp <= msgLamp;
                    lastCode <= msgCode;
                end
            end else if (msgValid) begin
                waitCnt <= waitCnt + 1;
                msgReady <= waitCnt >= (slow ? 4 : 0);
            end
        end
    end
endmodule

//--- tb/fdm_manager_test.sv
// self-checking bench for the fault trouble code manager
`timescale 1ns/100ps
module fdm_manager_test
    import fdm_pkg::*;
();
    localparam int PERIOD_CYCLES = 50;
    localparam int STARTUP_CYCLES = 100;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [NUM_CH-1:0] faultRaw = '0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, msgCode, lastCode, rd;
    logic [7:0] msgLamp, lastLamp;
    logic msgReady, msgValid, msgEmpty, irq, pready, pslverr, err;
    logic slow = 1'h0, clearCmd = 1'h0, clearActiveReq;
    logic clkEn = 1'h1;
    int fullCnt, emptyCnt, e, mismatches = 0, checksDone = 0, cyc = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    fdm_manager #(.PERIOD_CYCLES(PERIOD_CYCLES),
        .STARTUP_CYCLES(STARTUP_CYCLES)) dut (.clk(clk), .reset(reset),
        .clkEn(clkEn), .faultRaw(faultRaw), .clearActiveReq(clearActiveReq),
        .msgReady(msgReady), .msgValid(msgValid), .msgLamp(msgLamp),
        .msgCode(msgCode), .msgEmpty(msgEmpty), .irq(irq), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fdm_net_node u_node (.clk(clk), .reset(reset), .msgValid(msgValid),
        .msgLamp(msgLamp), .msgCode(msgCode), .msgEmpty(msgEmpty),
        .slow(slow), .clearCmd(clearCmd), .msgReady(msgReady),
        .clearActiveReq(clearActiveReq), .fullCnt(fullCnt),
        .emptyCnt(emptyCnt), .lastLamp(lastLamp), .lastCode(lastCode));
    ////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    // one apb transfer, read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp,
        input string what);
        apb(1'h0, a, 32'h0);
        check(rd, exp, what);
    endtask
    function automatic logic [11:0] ca(input int n, input logic [3:0] o);
        return ADDR_CH_BASE + 12'(n * 16) + 12'(o);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'h0;
        rdChk(ca(0, CH_CFG), 32'h0000011F, "cfg reset");
        rdChk(ca(0, CH_DLY), 32'h00000064, "delay reset");
        apb(1'h0, 12'h018, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'h1, ca(0, CH_SPN), 32'h00012345);
        apb(1'h1, ca(0, CH_CFG), 32'h00000203);
        apb(1'h1, ca(0, CH_DLY), 32'h0000000A);
        apb(1'h1, ADDR_MASK, 32'h00000001);
        repeat (2 * STARTUP_CYCLES) @(posedge clk);
        check(32'(emptyCnt > 0), 32'h1, "no periodic message");
        check(32'(fullCnt), 32'h0, "spurious code");
        $display("test startup done");
        faultRaw[0] <= 1'h1;
        repeat (5) @(posedge clk);
        faultRaw[0] <= 1'h0;
        repeat (20) @(posedge clk);
        rdChk(ca(0, CH_STA), 32'h00000000, "short fault kept");
        faultRaw[0] <= 1'h1;
        repeat (30) @(posedge clk);
        rdChk(ca(0, CH_STA), 32'h00000201, "not active");
        check(32'(fullCnt), 32'h1, "no code message");
        check({24'h0, lastLamp}, 32'h00000010, "lamp byte");
        check(lastCode, 32'h01232345, "code word");
        rdChk(ADDR_MSG1, 32'h01232345, "last code reg");
        rdChk(ADDR_STAT, 32'h00010001, "status word");
        rdChk(ADDR_IRQ, 32'h00000005, "irq status");
        check({31'h0, irq}, 32'h1, "irq not raised");
        apb(1'h1, ADDR_IRQ, 32'h00000001);
        @(posedge clk);
        check({31'h0, irq}, 32'h0, "irq not cleared");
        e = emptyCnt;
        faultRaw[0] <= 1'h0;
        repeat (12) @(posedge clk);
        rdChk(ca(0, CH_STA), 32'h00000301, "not previous");
        check(32'(emptyCnt > e), 32'h1, "no all-clear message");
        $display("test activate done");
        clkEn <= 1'h0;
        faultRaw[0] <= 1'h1;
        repeat (30) @(posedge clk);
        faultRaw[0] <= 1'h0;
        clkEn <= 1'h1;
        repeat (20) @(posedge clk);
        rdChk(ca(0, CH_STA), 32'h00000301, "enable low not frozen");
        $display("test freeze done");
        slow <= 1'h1;
        apb(1'h1, ca(0, CH_CFG), 32'h00001203);
        faultRaw[0] <= 1'h1;
        repeat (30) @(posedge clk);
        faultRaw[0] <= 1'h0;
        repeat (20) @(posedge clk);
        rdChk(ca(0, CH_STA), 32'h00000202, "latch dropped");
        check(32'(fullCnt), 32'h2, "stalled message lost");
        clearCmd <= 1'h1;
        repeat (10) @(posedge clk);
        clearCmd <= 1'h0;
        repeat (10) @(posedge clk);
        rdChk(ca(0, CH_STA), 32'h00000302, "clear ignored");
        $display("test latch done");
        apb(1'h1, ca(0, CH_CFG), 32'h00000019);
        rdChk(ca(0, CH_CFG), 32'h00000003, "bad mode taken");
        apb(1'h1, ca(0, CH_CFG), 32'h00000015);
        rdChk(ca(0, CH_CFG), 32'h00000015, "mode 21 refused");
        apb(1'h1, ca(0, CH_SPN), 32'h00000777);
        apb(1'h0, ca(0, CH_STA), 32'h0);
        check(rd & 32'h7F, 32'h0, "count kept");
        e = fullCnt;
        faultRaw[1] <= 1'h1;
        repeat (150) @(posedge clk);
        check(32'(fullCnt), 32'(e), "zero parameter sent");
        $display("test config done");
        end_of_test();
    end
endmodule
bind fdm_manager fdm_manager_asserts #(.PERIOD_CYCLES(PERIOD_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.clk(clk), .reset(reset),
    .clkEn(clkEn), .faultRaw(faultRaw), .clearActiveReq(clearActiveReq),
    .msgReady(msgReady), .msgValid(msgValid), .msgLamp(msgLamp),
    .msgCode(msgCode), .msgEmpty(msgEmpty), .irq(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
